// ==== shared/cmpst_pkg.sv ====
package cmpst_pkg;
	localparam int unsigned CMPST_AW = 5;
	localparam logic [4:0] CMPST_OFF_STATUS = 5'h08;
	localparam logic [4:0] CMPST_OFF_REFLVL = 5'h0C;
	localparam logic [4:0] CMPST_OFF_DELAY = 5'h10;
	localparam logic [31:0] CMPST_STATUS_RST = 32'h00000000;
	localparam logic [3:0] CMPST_REFLVL_RST = 4'h0;
	localparam logic [8:0] CMPST_DELAY_RST = 9'h000;
	localparam int unsigned CMPST_REFLVL_W = 4;
	localparam int unsigned CMPST_DELAY_W = 9;
	// Status field positions
	localparam int unsigned CMPST_B_CHG0 = 0;
	localparam int unsigned CMPST_B_CHG1 = 1;
	localparam int unsigned CMPST_B_DIR0 = 2;
	localparam int unsigned CMPST_B_DIR1 = 3;
	localparam int unsigned CMPST_B_DCHG0 = 4;
	localparam int unsigned CMPST_B_DCHG1 = 5;
	localparam int unsigned CMPST_B_DLY0 = 6;
	localparam int unsigned CMPST_B_DLY1 = 7;
	localparam int unsigned CMPST_SYNC_STAGES = 2;
endpackage

// ==== shared/cmpst_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cmpst_sync_if;
	logic [3:0] raw;
	logic [3:0] clean;
	modport src (output raw, input clean);
	modport snk (input raw, output clean);
endinterface
`default_nettype wire

// ==== core/cmpst_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpst_sync #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	cmpst_sync_if.snk sif
);
	import cmpst_pkg::*;
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;
	// First stage is read only by the second stage
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			stable_ff <= '0;
		end else begin
			meta_ff <= sif.raw;
			stable_ff <= meta_ff;
		end
	end
	assign sif.clean = stable_ff;
endmodule
`default_nettype wire

// ==== core/cmpst_regs.sv ====
// Overview of operation
// - Delayed results of comparator 1 and 0 appear synchronized in status bits 7 and 6.
// - Delayed result bits read zero while delay mode enable is low.
// - Delayed change flags bits 5 and 4 set on change; interrupt if enabled.
// - Any status flag clears when software writes one; writing zero keeps it.
// - Direct outputs of comparator 1 and 0 appear synchronized in bits 3 and 2.
// - Direct output bits read zero while the comparator enable is low.
// - Change flags bits 1 and 0 set on every change of direct bits 3 and 2 as gated by the comparator enable; interrupt if enabled.
// - Status register at offset 0x08, resets to zero, bits 31 to 8 reserved.
// - Reference level register at 0x0C, resets zero, 4-bit code in bits 3 to 0.
// - Delay count register at 0x10, read/write, resets to zero.
// - Delay count is 9 bits in bits 8 to 0; upper bits reserved.
// - Delay trigger mode runs only while its enable bit is one.
// - Comparator interrupt request passes only while its enable bit is one.
`timescale 1ns/1ps
`default_nettype none
module cmpst_regs (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [cmpst_pkg::CMPST_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] direct_raw_i,
	input wire logic [1:0] delayed_raw_i,
	input wire logic [1:0] comparator_enable_i,
	input wire logic delay_mode_enable_i,
	input wire logic [1:0] comparator_interrupt_enable_i,
	input wire logic delay_interrupt_enable_i,
	output logic [cmpst_pkg::CMPST_REFLVL_W-1:0] reference_code_o,
	output logic [cmpst_pkg::CMPST_DELAY_W-1:0] delay_count_o,
	output logic cmp_irq_o,
	output logic delay_irq_o
);
	import cmpst_pkg::*;

	cmpst_sync_if sif ();
	assign sif.raw = {delayed_raw_i, direct_raw_i};
	cmpst_sync #(.WIDTH(4)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.sif(sif)
	);

	logic [1:0] direct_sync;
	logic [1:0] delayed_sync;
	logic [1:0] direct_prev_ff;
	logic [1:0] delayed_prev_ff;
	logic [1:0] change_flag_ff;
	logic [1:0] delayed_change_flag_ff;
	logic [1:0] nxt_change_flag;
	logic [1:0] nxt_delayed_change_flag;
	logic [3:0] reference_level_code_ff;
	logic [8:0] trigger_delay_count_ff;
	logic [31:0] prdata_ff;
	logic [1:0] direct_result;
	logic [1:0] delayed_result;
	logic [1:0] direct_edge;
	logic [1:0] delayed_edge;
	logic [31:0] status_word;
	logic wr_access;
	logic rd_access;
	logic hit_status;
	logic hit_reflvl;
	logic hit_delay;
	logic mapped;
	logic [31:0] rd_mux;

	function automatic logic addr_hit(input logic [CMPST_AW-1:0] a, input logic [4:0] off);
		addr_hit = (a == off[CMPST_AW-1:0]);
	endfunction

	assign direct_sync = sif.clean[1:0];
	assign delayed_sync = sif.clean[3:2];
	assign direct_result = direct_sync & comparator_enable_i;
	assign delayed_result = delayed_sync & {2{delay_mode_enable_i}};
	// Edges taken on gated values, so enabling a unit can itself flag a change
	assign direct_edge = direct_result ^ direct_prev_ff;
	assign delayed_edge = delayed_result ^ delayed_prev_ff;

	assign wr_access = psel_i & penable_i & pwrite_i;
	assign rd_access = psel_i & ~penable_i & ~pwrite_i;
	assign hit_status = addr_hit(paddr_i, CMPST_OFF_STATUS);
	assign hit_reflvl = addr_hit(paddr_i, CMPST_OFF_REFLVL);
	assign hit_delay = addr_hit(paddr_i, CMPST_OFF_DELAY);
	assign mapped = hit_status | hit_reflvl | hit_delay;

	// Set wins over a simultaneous write-one clear
	assign nxt_change_flag = (change_flag_ff &
		~({2{wr_access & hit_status}} & pwdata_i[CMPST_B_CHG1:CMPST_B_CHG0])) | direct_edge;
	assign nxt_delayed_change_flag = (delayed_change_flag_ff &
		~({2{wr_access & hit_status}} & pwdata_i[CMPST_B_DCHG1:CMPST_B_DCHG0])) | delayed_edge;

	assign status_word = {24'h000000, delayed_result, delayed_change_flag_ff,
		direct_result, change_flag_ff};
	assign rd_mux = hit_status ? status_word :
		hit_reflvl ? {28'h0000000, reference_level_code_ff} :
		hit_delay ? {23'h000000, trigger_delay_count_ff} : 32'h00000000;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			direct_prev_ff <= 2'h0;
			delayed_prev_ff <= 2'h0;
			change_flag_ff <= CMPST_STATUS_RST[1:0];
			delayed_change_flag_ff <= CMPST_STATUS_RST[5:4];
		end else begin
			direct_prev_ff <= direct_result;
			delayed_prev_ff <= delayed_result;
			change_flag_ff <= nxt_change_flag;
			delayed_change_flag_ff <= nxt_delayed_change_flag;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reference_level_code_ff <= CMPST_REFLVL_RST;
			trigger_delay_count_ff <= CMPST_DELAY_RST;
		end else if (wr_access) begin
			if (hit_reflvl) begin
				reference_level_code_ff <= pwdata_i[3:0];
			end
			if (hit_delay) begin
				trigger_delay_count_ff <= pwdata_i[8:0];
			end
		end
	end

	// Read data captured in setup phase, stable through access phase
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_ff <= 32'h00000000;
		end else if (rd_access) begin
			prdata_ff <= rd_mux;
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign reference_code_o = reference_level_code_ff;
	assign delay_count_o = trigger_delay_count_ff;
	assign cmp_irq_o = |(change_flag_ff & comparator_interrupt_enable_i);
	assign delay_irq_o = delay_interrupt_enable_i & delay_mode_enable_i & (|delayed_change_flag_ff);
endmodule
`default_nettype wire

// ==== verif/cmpst_cmp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpst_cmp_model (
	input wire logic sys_clk_i,
	input wire logic [3:0] level_i,
	output logic [1:0] direct_o,
	output logic [1:0] delayed_o
);
	// Outputs move on the rising clock edge, the same edge the synchronizer samples on
	always @(posedge sys_clk_i) begin
		{delayed_o, direct_o} <= level_i;
	end
endmodule
`default_nettype wire

// ==== verif/cmpst_regs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpst_regs_props (
	input wire logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, delay_mode_enable_i, delay_interrupt_enable_i,
	input wire logic [4:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic pslverr_o, cmp_irq_o, delay_irq_o,
	input wire logic [1:0] direct_raw_i, comparator_enable_i, comparator_interrupt_enable_i,
	input wire logic [3:0] reference_code_o,
	input wire logic [8:0] delay_count_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic acc = psel_i & penable_i;
	wire logic hit = paddr_i == 5'h08 || paddr_i == 5'h0C || paddr_i == 5'h10;
	sequence s_ref_wr;
		acc && pwrite_i && paddr_i == 5'h0C;
	endsequence
	sequence s_dly_wr;
		acc && pwrite_i && paddr_i == 5'h10;
	endsequence
	a_ref_load: assert property (s_ref_wr |=> reference_code_o == $past(pwdata_i[3:0]))
		else $error("reference code not loaded");
	a_ref_hold: assert property (!(acc && pwrite_i && paddr_i == 5'h0C) |=> $stable(reference_code_o))
		else $error("reference code moved");
	a_dly_load: assert property (s_dly_wr |=> delay_count_o == $past(pwdata_i[8:0]))
		else $error("delay count not loaded");
	a_err_unmapped: assert property (acc && !hit |-> pslverr_o)
		else $error("no error on unmapped");
	a_err_mapped: assert property (acc && hit |-> !pslverr_o)
		else $error("error on mapped");
	a_upper_zero: assert property (prdata_o[31:9] == 23'h0)
		else $error("reserved read bits set");
	a_irq_gate: assert property (comparator_interrupt_enable_i == 2'h0 |-> !cmp_irq_o)
		else $error("masked irq raised");
	a_dirq_gate: assert property (!delay_interrupt_enable_i || !delay_mode_enable_i |-> !delay_irq_o)
		else $error("masked delay irq raised");
	a_irq_set: assert property ($changed(direct_raw_i[0]) && comparator_enable_i[0] && comparator_interrupt_enable_i[0]
		|-> ##[1:5] cmp_irq_o)
		else $error("change gave no irq");
endmodule
bind cmpst_regs cmpst_regs_props chk_u (.*);
`default_nettype wire

// ==== verif/cmpst_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpst_regs_test;
	logic sys_clk_i = 1'h0, rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic delay_mode_enable_i = 1'h0, delay_interrupt_enable_i = 1'h0, pready_o, pslverr_o, cmp_irq_o, delay_irq_o;
	logic [4:0] paddr_i = 5'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic [1:0] comparator_enable_i = 2'h0, comparator_interrupt_enable_i = 2'h0, direct_raw_i, delayed_raw_i;
	logic [3:0] level = 4'h0, reference_code_o;
	logic [8:0] delay_count_o;
	int fails = 0, check_count = 0, cyc = 0;
	cmpst_regs dut_u (.*);
	cmpst_cmp_model cmp_u (.sys_clk_i, .level_i(level), .direct_o(direct_raw_i), .delayed_o(delayed_raw_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	task close_out;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			close_out();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(negedge sys_clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i} = {1'h1, w, a, d};
		@(negedge sys_clk_i);
		penable_i = 1'h1;
		@(negedge sys_clk_i);
		{psel_i, penable_i, pwrite_i} = 3'h0;
	endtask
	task rc(input logic [4:0] a, input logic [31:0] e);
		acc(1'h0, a, 32'h0);
		chk(prdata_o, e);
	endtask
	initial begin
		repeat (20) @(negedge sys_clk_i);
		rst_i = 1'h0;
		rc(5'h08, 32'h0);
		rc(5'h0C, 32'h0);
		rc(5'h10, 32'h0);
		acc(1'h1, 5'h0C, 32'hFFFFFFFF);
		acc(1'h1, 5'h10, 32'hFFFFFFFF);
		acc(1'h1, 5'h08, 32'hFFFFFFFF);
		rc(5'h0C, 32'h0000000F);
		rc(5'h10, 32'h000001FF);
		chk(reference_code_o, 32'h0000000F);
		chk(delay_count_o, 32'h000001FF);
		chk(pready_o, 32'h1);
		rc(5'h14, 32'h0);
		rc(5'h08, 32'h0);
		$display("test registers done");
		{comparator_enable_i, comparator_interrupt_enable_i} = 4'hF;
		{delay_mode_enable_i, delay_interrupt_enable_i, level} = 6'h3F;
		repeat (6) @(negedge sys_clk_i);
		rc(5'h08, 32'h000000FF);
		chk(cmp_irq_o, 32'h1);
		chk(delay_irq_o, 32'h1);
		acc(1'h1, 5'h08, 32'h1);
		rc(5'h08, 32'h000000FE);
		acc(1'h1, 5'h08, 32'hFF);
		rc(5'h08, 32'h000000CC);
		chk({cmp_irq_o, delay_irq_o}, 32'h0);
		$display("test flags done");
		// Dropping enables with outputs high counts as a change
		{comparator_enable_i, comparator_interrupt_enable_i, delay_mode_enable_i} = 5'h0;
		repeat (6) @(negedge sys_clk_i);
		rc(5'h08, 32'h00000033);
		chk({cmp_irq_o, delay_irq_o}, 32'h0);
		$display("test disable done");
		close_out();
	end
endmodule
`default_nettype wire
